/* bmw_pkg.sv */
// Constants for the bridge memory window configuration registers.
// Assumes a dword-wide configuration access port with byte enables.
package bmw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int          CFG_AW            = 8;
  localparam logic [7:0]  OFF_MEM_DWORD     = 8'h20;
  localparam logic [7:0]  OFF_MEM_FLOOR     = 8'h20;
  localparam logic [7:0]  OFF_MEM_CEILING   = 8'h22;
  localparam logic [7:0]  OFF_PREF_DWORD    = 8'h24;
  localparam logic [7:0]  OFF_PREF_FLOOR    = 8'h24;
  localparam logic [7:0]  OFF_PREF_CEILING  = 8'h26;
  localparam logic [7:0]  OFF_PREF_FLOOR_HI = 8'h28;
  localparam logic [7:0]  OFF_PREF_CEIL_HI  = 8'h2c;

  ////////////////////////////////////////////////////////////////////////////
  localparam int          WIN_FIELD_LSB     = 4;
  localparam int          WIN_FIELD_MSB     = 15;
  localparam logic [15:0] WIN_WRITE_MASK    = 16'hfff0;
  localparam logic [15:0] MEM_RSVD_VALUE    = 16'h0000;
  localparam logic [15:0] WIDE_ADDRESS_FLAG = 16'h0001;
  localparam logic [15:0] MEM_WIN_RESET     = 16'h0000;
  localparam logic [15:0] PREF_WIN_RESET    = 16'h0001;
  localparam logic [31:0] PREF_HI_RESET     = 32'h0000_0000;
  localparam logic [19:0] FLOOR_LOW_BITS    = 20'h00000;
  localparam logic [19:0] CEILING_LOW_BITS  = 20'hfffff;
  localparam int          READ_LATENCY      = 1;

endpackage

/* bmw_window_match.sv */
// Address range comparator for one forwarding window.
// Assumes floor and ceiling are already expanded to full 64-bit byte addresses.
`timescale 1ns/1ps
module bmw_window_match
  import bmw_pkg::*;
(
  input  wire logic [63:0] addr_i,
  input  wire logic [63:0] floor_i,
  input  wire logic [63:0] ceiling_i,
  output logic             hit_o
);

  // A floor above the ceiling gives an empty window and never hits.
  always_comb begin
    hit_o = (addr_i >= floor_i) && (addr_i <= ceiling_i);
  end

endmodule

/* bmw_regs.sv */
// Operation
// - Memory floor field bits 15:4 form address 31:20, low twenty bits zero.
// - Memory ceiling field bits 15:4 form address 31:20, low twenty bits ones.
// - Memory floor and ceiling bits 3:0 always read zero.
// - Prefetch floor bits 15:4 give address 31:20; upper register gives 63:32.
// - Prefetch ceiling bits 15:4 give 31:20, ones below; upper gives 63:32.
// - Prefetch floor and ceiling bits 3:0 read one, flagging 64-bit support.
// - Reset clears memory floor and ceiling registers to zero.
// - Forward a memory transaction whose address lies inside either window.
// - Upper prefetch floor and ceiling registers are read/write, reset to zero.
//
// Memory window configuration registers and the downstream forward decision.
// Assumes configuration requests and transaction lookups come from logic on
// the same clock, so no input is synchronised.
// Assumes one dword configuration port with byte enables and one cycle of
// read latency; reads and lookups are answered from registers.
`timescale 1ns/1ps
module bmw_regs
  import bmw_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              rstn_i,
  input  wire logic              cfg_wr_i,
  input  wire logic              cfg_rd_i,
  input  wire logic [CFG_AW-1:0] cfg_addr_i,
  input  wire logic [3:0]        cfg_be_i,
  input  wire logic [31:0]       cfg_wdata_i,
  output logic      [31:0]       cfg_rdata_o,
  output logic                   cfg_rvalid_o,
  input  wire logic              txn_valid_i,
  input  wire logic [63:0]       txn_addr_i,
  output logic                   fwd_valid_o,
  output logic                   fwd_hit_o,
  output logic                   fwd_mem_hit_o,
  output logic                   fwd_pref_hit_o
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] be_to_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] mask);
    return (old_v & ~mask) | (new_v & mask);
  endfunction

  // Bits 1:0 of the offset never select a register; every decode is by dword.
  function automatic logic [CFG_AW-1:0] dword_of(input logic [CFG_AW-1:0] addr);
    return {addr[CFG_AW-1:2], 2'b00};
  endfunction

  function automatic logic [11:0] win_field(input logic [15:0] half);
    return half[WIN_FIELD_MSB:WIN_FIELD_LSB];
  endfunction

  function automatic logic [15:0] window_half(input logic [11:0] field,
                                              input logic [3:0]  low);
    return {field, low};
  endfunction

  function automatic logic [63:0] floor_addr(input logic [31:0] hi,
                                             input logic [11:0] field);
    return {hi, field, FLOOR_LOW_BITS};
  endfunction

  function automatic logic [63:0] ceiling_addr(input logic [31:0] hi,
                                               input logic [11:0] field);
    return {hi, field, CEILING_LOW_BITS};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [11:0] window_floor_bits_r,     window_floor_bits_nxt;
  logic [11:0] window_ceiling_bits_r,   window_ceiling_bits_nxt;
  logic [11:0] prefetch_floor_bits_r,   prefetch_floor_bits_nxt;
  logic [11:0] prefetch_ceiling_bits_r, prefetch_ceiling_bits_nxt;
  logic [31:0] pref_floor_hi_r,         pref_floor_hi_nxt;
  logic [31:0] pref_ceil_hi_r,          pref_ceil_hi_nxt;
  logic [31:0] cfg_rdata_r,             cfg_rdata_nxt;
  logic        cfg_rvalid_r,            cfg_rvalid_nxt;

  logic [15:0] memory_window_floor;
  logic [15:0] memory_window_ceiling;
  logic [15:0] prefetch_window_floor;
  logic [15:0] prefetch_window_ceiling;
  logic [31:0] wmask;
  logic [31:0] dw_mem;
  logic [31:0] dw_pref;

  always_comb begin
    memory_window_floor     = window_half(window_floor_bits_r, MEM_RSVD_VALUE[3:0]);
    memory_window_ceiling   = window_half(window_ceiling_bits_r, MEM_RSVD_VALUE[3:0]);
    prefetch_window_floor   = window_half(prefetch_floor_bits_r,
                                          WIDE_ADDRESS_FLAG[3:0]);
    prefetch_window_ceiling = window_half(prefetch_ceiling_bits_r,
                                          WIDE_ADDRESS_FLAG[3:0]);
    dw_mem  = {memory_window_ceiling, memory_window_floor};
    dw_pref = {prefetch_window_ceiling, prefetch_window_floor};
    wmask   = be_to_mask(cfg_be_i);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offset decode shared by every register group; the read path decodes the offset again itself.
  logic        sel_mem;
  logic        sel_pref;
  logic        sel_floor_hi;
  logic        sel_ceil_hi;
  logic [31:0] win_wmask;

  always_comb begin
    sel_mem      = 1'b0;
    sel_pref     = 1'b0;
    sel_floor_hi = 1'b0;
    sel_ceil_hi  = 1'b0;
    case (dword_of(cfg_addr_i))
      OFF_MEM_DWORD:     sel_mem      = 1'b1;
      OFF_PREF_DWORD:    sel_pref     = 1'b1;
      OFF_PREF_FLOOR_HI: sel_floor_hi = 1'b1;
      OFF_PREF_CEIL_HI:  sel_ceil_hi  = 1'b1;
      default: begin
      end
    endcase
    win_wmask = wmask & {WIN_WRITE_MASK, WIN_WRITE_MASK};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Non-prefetchable window fields. The reserved nibbles have no storage, so
  // no write can ever make them read back anything but zero.
  logic [31:0] m_mem;

  always_comb begin
    m_mem                   = merge(dw_mem, cfg_wdata_i, win_wmask);
    window_floor_bits_nxt   = window_floor_bits_r;
    window_ceiling_bits_nxt = window_ceiling_bits_r;
    if (cfg_wr_i && sel_mem) begin
      window_floor_bits_nxt   = win_field(m_mem[15:0]);
      window_ceiling_bits_nxt = win_field(m_mem[31:16]);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      window_floor_bits_r   <= MEM_WIN_RESET[WIN_FIELD_MSB:WIN_FIELD_LSB];
      window_ceiling_bits_r <= MEM_WIN_RESET[WIN_FIELD_MSB:WIN_FIELD_LSB];
    end else begin
      window_floor_bits_r   <= window_floor_bits_nxt;
      window_ceiling_bits_r <= window_ceiling_bits_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prefetchable window fields. The low nibble of each half is the wide
  // address flag, wired to a constant so that software cannot clear it.
  logic [31:0] m_pref;

  always_comb begin
    m_pref                    = merge(dw_pref, cfg_wdata_i, win_wmask);
    prefetch_floor_bits_nxt   = prefetch_floor_bits_r;
    prefetch_ceiling_bits_nxt = prefetch_ceiling_bits_r;
    if (cfg_wr_i && sel_pref) begin
      prefetch_floor_bits_nxt   = win_field(m_pref[15:0]);
      prefetch_ceiling_bits_nxt = win_field(m_pref[31:16]);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prefetch_floor_bits_r   <= PREF_WIN_RESET[WIN_FIELD_MSB:WIN_FIELD_LSB];
      prefetch_ceiling_bits_r <= PREF_WIN_RESET[WIN_FIELD_MSB:WIN_FIELD_LSB];
    end else begin
      prefetch_floor_bits_r   <= prefetch_floor_bits_nxt;
      prefetch_ceiling_bits_r <= prefetch_ceiling_bits_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Upper halves of the prefetchable window. Every enabled byte is stored;
  // a floor above the ceiling simply leaves the window empty.
  always_comb begin
    pref_floor_hi_nxt = pref_floor_hi_r;
    pref_ceil_hi_nxt  = pref_ceil_hi_r;
    if (cfg_wr_i && sel_floor_hi) begin
      pref_floor_hi_nxt = merge(pref_floor_hi_r, cfg_wdata_i, wmask);
    end
    if (cfg_wr_i && sel_ceil_hi) begin
      pref_ceil_hi_nxt = merge(pref_ceil_hi_r, cfg_wdata_i, wmask);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pref_floor_hi_r <= PREF_HI_RESET;
      pref_ceil_hi_r  <= PREF_HI_RESET;
    end else begin
      pref_floor_hi_r <= pref_floor_hi_nxt;
      pref_ceil_hi_r  <= pref_ceil_hi_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path. A read in the same cycle as a write returns the old contents,
  // because the word is taken from the registers before the edge.
  always_comb begin
    cfg_rvalid_nxt = cfg_rd_i;
    cfg_rdata_nxt  = cfg_rdata_r;
    if (cfg_rd_i) begin
      case (dword_of(cfg_addr_i))
        OFF_MEM_DWORD:     cfg_rdata_nxt = dw_mem;
        OFF_PREF_DWORD:    cfg_rdata_nxt = dw_pref;
        OFF_PREF_FLOOR_HI: cfg_rdata_nxt = pref_floor_hi_r;
        OFF_PREF_CEIL_HI:  cfg_rdata_nxt = pref_ceil_hi_r;
        default:           cfg_rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_rdata_r  <= 32'h0000_0000;
      cfg_rvalid_r <= 1'b0;
    end else begin
      cfg_rdata_r  <= cfg_rdata_nxt;
      cfg_rvalid_r <= cfg_rvalid_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The non-prefetchable window decodes only 32-bit space, so its upper half
  // is pinned to zero and any address above 4 GB misses it.
  logic [63:0] mem_floor;
  logic [63:0] mem_ceiling;
  logic [63:0] pref_floor;
  logic [63:0] pref_ceiling;
  logic        mem_hit;
  logic        pref_hit;

  always_comb begin
    mem_floor    = floor_addr(32'h0000_0000, window_floor_bits_r);
    mem_ceiling  = ceiling_addr(32'h0000_0000, window_ceiling_bits_r);
    pref_floor   = floor_addr(pref_floor_hi_r, prefetch_floor_bits_r);
    pref_ceiling = ceiling_addr(pref_ceil_hi_r, prefetch_ceiling_bits_r);
  end

  bmw_window_match u_mem_match (
    .addr_i    (txn_addr_i),
    .floor_i   (mem_floor),
    .ceiling_i (mem_ceiling),
    .hit_o     (mem_hit)
  );

  bmw_window_match u_pref_match (
    .addr_i    (txn_addr_i),
    .floor_i   (pref_floor),
    .ceiling_i (pref_ceiling),
    .hit_o     (pref_hit)
  );

  // Lookup answers come one cycle after the request, like read data, so a
  // caller sees every answer from a flip-flop.
  logic fwd_valid_r,    fwd_valid_nxt;
  logic fwd_hit_r,      fwd_hit_nxt;
  logic fwd_mem_hit_r,  fwd_mem_hit_nxt;
  logic fwd_pref_hit_r, fwd_pref_hit_nxt;

  always_comb begin
    fwd_valid_nxt    = txn_valid_i;
    fwd_mem_hit_nxt  = txn_valid_i && mem_hit;
    fwd_pref_hit_nxt = txn_valid_i && pref_hit;
    fwd_hit_nxt      = txn_valid_i && (mem_hit || pref_hit);
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fwd_valid_r    <= 1'b0;
      fwd_hit_r      <= 1'b0;
      fwd_mem_hit_r  <= 1'b0;
      fwd_pref_hit_r <= 1'b0;
    end else begin
      fwd_valid_r    <= fwd_valid_nxt;
      fwd_hit_r      <= fwd_hit_nxt;
      fwd_mem_hit_r  <= fwd_mem_hit_nxt;
      fwd_pref_hit_r <= fwd_pref_hit_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign cfg_rdata_o    = cfg_rdata_r;
  assign cfg_rvalid_o   = cfg_rvalid_r;
  assign fwd_valid_o    = fwd_valid_r;
  assign fwd_hit_o      = fwd_hit_r;
  assign fwd_mem_hit_o  = fwd_mem_hit_r;
  assign fwd_pref_hit_o = fwd_pref_hit_r;

endmodule

/* bmw_regs_sva.sv */
// Concurrent checks on the memory window register block ports.
// Assumes it is bound into bmw_regs and sees only that module's ports.
`timescale 1ns/1ps
module bmw_regs_sva
  import bmw_pkg::*;
(
  input wire logic              ref_clk_i,
  input wire logic              rstn_i,
  input wire logic              cfg_wr_i,
  input wire logic              cfg_rd_i,
  input wire logic [CFG_AW-1:0] cfg_addr_i,
  input wire logic [3:0]        cfg_be_i,
  input wire logic [31:0]       cfg_wdata_i,
  input wire logic [31:0]       cfg_rdata_o,
  input wire logic              cfg_rvalid_o,
  input wire logic              txn_valid_i,
  input wire logic [63:0]       txn_addr_i,
  input wire logic              fwd_valid_o,
  input wire logic              fwd_hit_o,
  input wire logic              fwd_mem_hit_o,
  input wire logic              fwd_pref_hit_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////////////////////////////////////////
  read_answer_a: assert property (cfg_rd_i |=> cfg_rvalid_o)
    else $error("read not answered");
  read_quiet_a: assert property (!cfg_rd_i |=> !cfg_rvalid_o && $stable(cfg_rdata_o))
    else $error("read data moved without a read");
  mem_rsvd_a: assert property (cfg_rd_i && cfg_addr_i[7:2] == OFF_MEM_DWORD[7:2]
    |=> cfg_rdata_o[3:0] == 4'h0 && cfg_rdata_o[19:16] == 4'h0)
    else $error("reserved bits not zero");
  wide_flag_a: assert property (cfg_rd_i && cfg_addr_i[7:2] == OFF_PREF_DWORD[7:2]
    |=> cfg_rdata_o[3:0] == 4'h1 && cfg_rdata_o[19:16] == 4'h1)
    else $error("wide address flag wrong");
  lookup_answer_a: assert property (fwd_valid_o == $past(txn_valid_i))
    else $error("lookup answer timing wrong");
  hit_union_a: assert property (fwd_hit_o == (fwd_mem_hit_o || fwd_pref_hit_o))
    else $error("hit is not the union of windows");
  hit_gated_a: assert property (!fwd_valid_o |-> !fwd_mem_hit_o && !fwd_pref_hit_o)
    else $error("hit without lookup");
  mem_narrow_a: assert property (txn_valid_i && txn_addr_i[63:32] != 32'h0
    |=> !fwd_mem_hit_o)
    else $error("memory window hit above 4 GB");
endmodule
bind bmw_regs bmw_regs_sva u_bmw_regs_sva (.*);

/* test_bmw_regs.sv */
// Self-checking bench for the memory window registers.
// Assumes one 200 MHz clock; inputs change at the falling edge.
`timescale 1ns/1ps
module test_bmw_regs
  import bmw_pkg::*;
  ;
  logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, tv = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [3:0]  be = 4'h0;
  logic [31:0] wd = 32'h0, rdata, m [4], rq [$];
  logic [63:0] ta = 64'h0;
  logic        rv, fv, fh, fmh, fph;
  logic [2:0]  fq [$];
  int          mismatches = 0, compares = 0;
  bmw_regs u_bmw_regs (.ref_clk_i(clk), .rstn_i(rstn), .cfg_wr_i(wr), .cfg_rd_i(rd),
    .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wd), .cfg_rdata_o(rdata),
    .cfg_rvalid_o(rv), .txn_valid_i(tv), .txn_addr_i(ta), .fwd_valid_o(fv),
    .fwd_hit_o(fh), .fwd_mem_hit_o(fmh), .fwd_pref_hit_o(fph));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // The model is updated before the drive so back-to-back requests see it in order.
  task automatic wrc(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    logic [31:0] k;
    k = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    if (a[7:4] == 4'h2) begin
      if (!a[3]) k = k & {WIN_WRITE_MASK, WIN_WRITE_MASK};
      m[a[3:2]] = (m[a[3:2]] & ~k) | (d & k);
    end
    @(negedge clk);
    {wr, rd, tv, addr, be, wd} = {3'b100, a, b, d};
  endtask
  task automatic rdc(input logic [7:0] a);
    rq.push_back(a[7:4] == 4'h2 ? m[a[3:2]] : 32'h0);
    @(negedge clk);
    {wr, rd, tv, addr, be} = {3'b010, a, 4'($urandom())};
  endtask
  task automatic lk(input logic [63:0] a);
    logic mh, ph;
    mh = a >= {32'h0, m[0][15:4], 20'h0} && a <= {32'h0, m[0][31:20], 20'hfffff};
    ph = a >= {m[2], m[1][15:4], 20'h0} && a <= {m[3], m[1][31:20], 20'hfffff};
    fq.push_back({mh | ph, mh, ph});
    @(negedge clk);
    {wr, rd, tv, ta} = {3'b001, a};
  endtask
  function automatic logic [63:0] edge_addr(input logic [2:0] s);
    logic [63:0] f, c;
    f = s[2] ? {m[2], m[1][15:4], 20'h0} : {32'h0, m[0][15:4], 20'h0};
    c = s[2] ? {m[3], m[1][31:20], 20'hfffff} : {32'h0, m[0][31:20], 20'hfffff};
    return s[1] ? c + 64'(s[0]) : f - 64'(s[0]);
  endfunction
  task automatic drain(input string n);
    @(negedge clk);
    {wr, rd, tv} = 3'b000;
    repeat (4) @(negedge clk);
    chk("pending", 64'(rq.size() + fq.size()), 64'h0);
    $display("test %s done", n);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge clk) begin
    if (rv === 1'b1) chk("rdata", rdata, rq.size() ? rq.pop_front() : 32'hx);
    if (fv === 1'b1) chk("hits", {fh, fmh, fph}, fq.size() ? fq.pop_front() : 3'hx);
  end
  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    logic [31:0] r;
    void'($urandom(32'h9ccf));
    for (int p = 0; p < 2; p++) begin
      m = '{32'h0, {PREF_WIN_RESET, PREF_WIN_RESET}, 32'h0, 32'h0};
      rstn = 1'b0;
      repeat (10) @(negedge clk);
      rstn = 1'b1;
      for (int i = 0; i < 5; i++) rdc(8'h20 + 8'(4 * i));
      lk(64'h0);
      lk(64'h000f_ffff);
      lk(64'h0010_0000);
      drain("reset values");
    end
    // All-ones writes show that only the window fields and the upper prefetch registers take data.
    for (int i = 0; i < 5; i++) wrc(8'h20 + 8'(4 * i), 4'hf, 32'hffff_ffff);
    for (int i = 0; i < 5; i++) rdc(8'h20 + 8'(4 * i));
    drain("write masks");
    for (int i = 0; i < 400; i++) begin
      r = $urandom();
      case (r[1:0])
        2'd0: wrc(8'h20 + 8'(4 * (r[4:2] % 5)), r[8:5], $urandom());
        2'd1: rdc(8'h20 + 8'(4 * (r[4:2] % 5)));
        default: lk(r[9] ? edge_addr(r[4:2]) : {32'(r[10]), $urandom()});
      endcase
    end
    drain("random windows");
    stop_test();
  end
endmodule
